// ---- bench/acr1_fifo_model.sv ----
`timescale 1ns/1ps
module acr1_fifo_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Device side
	input wire logic wr,
	input wire logic [11:0] wdata,
	input wire logic rd,
	input wire logic flush,
	output logic [4:0] level,
	output logic [11:0] head
);
	logic [4:0] level_r, level_nxt;
	logic [11:0] head_r, head_nxt;

	// Only the fill count is modelled; head shows the newest word
	always_comb begin
		level_nxt = level_r;
		head_nxt = head_r;
		if (wr && level_r != 5'h10) begin
			level_nxt = level_nxt + 5'h01;
			head_nxt = wdata;
		end
		if (rd && level_r != 5'h00)
			level_nxt = level_nxt - 5'h01;
		if (flush)
			level_nxt = 5'h00;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			level_r <= 5'h00;
			head_r <= 12'h000;
		end else begin
			level_r <= level_nxt;
			head_r <= head_nxt;
		end
	end

	assign level = level_r;
	assign head = head_r;
endmodule

// ---- bench/test_adc_control_register_one.sv ----
`timescale 1ns/1ps
module test_adc_control_register_one;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic cs0_n = 1'b1;
	logic cs1 = 1'b0;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [11:0] din = 12'h000;
	logic conv = 1'b0;
	logic conv_run = 1'b0;
	logic ovf = 1'b0;
	logic [11:0] sample = 12'h800;
	logic ce = 1'b1;
	logic [11:0] dout, wdata, fdata, v;
	logic oe, fz, fwr, frd, ffl, dav;
	logic [4:0] lvl;
	logic [9:0] cr0;
	int num_errors = 0;
	int samples_checked = 0;
	int conv_cnt = 0;

	always #50 clk_sys = ~clk_sys;

	// Conversion clock: slower than clk_sys/4, parked low when stopped
	always begin
		repeat (4) @(posedge clk_sys);
		#5;
		conv = conv_run ? ~conv : 1'b0;
	end
	always @(posedge conv) conv_cnt++;

	acr1_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(ce),
		.chip_select_low_n(cs0_n), .chip_select_high(cs1),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n),
		.bus_data_in(din), .bus_data_out(dout), .bus_data_oe(oe),
		.conversion_clock_in(conv), .adc_sample_in(sample),
		.force_zero_out(fz), .fifo_level_in(lvl),
		.fifo_overflow_in(ovf), .fifo_data_in(fdata),
		.fifo_wr_out(fwr), .fifo_wdata_out(wdata), .fifo_rd_out(frd),
		.fifo_flush_out(ffl), .cr0_out(cr0), .data_available_out(dav));

	acr1_fifo_model fifo (.clk_sys(clk_sys), .rst_b(rst_b), .wr(fwr),
		.wdata(wdata), .rd(frd), .flush(ffl), .level(lvl), .head(fdata));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string what, input logic [11:0] exp,
		input logic [11:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#5;
	endtask

	// Watched outputs: 0 FIFO write, 1 force zero, 2 data available
	function automatic logic sig_of(input int w);
		return (w == 0) ? fwr : ((w == 1) ? fz : dav);
	endfunction

	// Bounded wait, looked at after each edge has settled
	task automatic wait_val(input int w, input logic x, input string what);
		for (int i = 0; i < 400 && sig_of(w) !== x; i++)
			cyc(1);
		if (sig_of(w) !== x) begin
			num_errors++;
			$display("BAD %s expected %b seen %b", what, x, sig_of(w));
			tally_and_finish();
		end
	endtask

	// Strobes are synchronised, so each phase spans several clocks
	task automatic bus_wr(input logic [11:0] d);
		cs0_n = 1'b0;
		cs1 = 1'b1;
		wr_n = 1'b0;
		din = d;
		cyc(4);
		cs0_n = 1'b1;
		cs1 = 1'b0;
		wr_n = 1'b1;
		cyc(5);
	endtask

	// Combined mode leaves the read pin high and reads with wr_n high
	task automatic bus_rd(input logic comb, output logic [11:0] d);
		cs0_n = 1'b0;
		cs1 = 1'b1;
		rd_n = comb;
		cyc(5);
		chk("oe", 12'h001, {11'h000, oe});
		d = dout;
		cs0_n = 1'b1;
		cs1 = 1'b0;
		rd_n = 1'b1;
		cyc(5);
	endtask

	task automatic one_sample();
		conv_run = 1'b1;
		wait_val(0, 1'b1, "fifo write");
		v = wdata;
		conv_run = 1'b0;
		cyc(8);
	endtask

	initial begin
		cyc(4);
		rst_b = 1'b1;
		cyc(3);
		chk("cr0 reset", 12'h020, {2'h0, cr0});
		bus_wr(12'h630);
		bus_rd(1'b0, v);
		chk("readback cr0", 12'h020, v);
		bus_rd(1'b0, v);
		chk("readback cr1", 12'h630, v);
		ovf = 1'b1;
		cyc(1);
		ovf = 1'b0;
		cyc(2);
		bus_rd(1'b0, v);
		bus_rd(1'b0, v);
		chk("overflow set", 12'h632, v);
		bus_rd(1'b0, v);
		bus_rd(1'b0, v);
		chk("overflow cleared", 12'h630, v);
		$display("test readback done");

		bus_wr(12'h325);
		chk("cr0 route", 12'h325, {2'h0, cr0});
		bus_wr(12'hc55);
		chk("cr0 route 11", 12'h055, {2'h0, cr0});
		// A write made while the enable is low must leave no trace
		ce = 1'b0;
		bus_wr(12'h3aa);
		ce = 1'b1;
		cyc(3);
		chk("frozen cr0", 12'h055, {2'h0, cr0});
		for (int k = 0; k < 2; k++) begin
			conv_cnt = 0;
			one_sample();
			chk("startup rises", 12'h005, conv_cnt[11:0]);
			if (k == 0) begin
				bus_wr(12'h401);
				chk("soft reset cr0", 12'h020, {2'h0, cr0});
				chk("soft reset fifo", 12'h000, {7'h00, lvl});
			end
		end
		bus_wr(12'h432);
		chk("flush level", 12'h000, {7'h00, lvl});
		$display("test reset and flush done");

		bus_wr(12'h4b0);
		sample = 12'h810;
		one_sample();
		chk("binary sample", 12'h810, v);
		sample = 12'h805;
		bus_wr(12'h5b0);
		chk("force zero", 12'h001, {11'h000, fz});
		conv_run = 1'b1;
		wait_val(1, 1'b0, "force zero drop");
		conv_run = 1'b0;
		cyc(8);
		sample = 12'h810;
		one_sample();
		chk("offset binary", 12'h80b, v);
		bus_wr(12'h430);
		one_sample();
		chk("offset twos", 12'h00b, v);
		$display("test format and offset done");

		bus_wr(12'h402);
		cyc(3);
		chk("avail idle low pol", 12'h001, {11'h000, dav});
		one_sample();
		wait_val(2, 1'b0, "avail active");
		bus_rd(1'b0, v);
		chk("avail after read", 12'h001, {11'h000, dav});
		chk("fifo pop", 12'h000, {7'h00, lvl});
		// Two channels: lowest trigger code needs two samples
		bus_wr(12'h080);
		bus_wr(12'h402);
		one_sample();
		chk("thr2 below", 12'h001, {11'h000, dav});
		one_sample();
		chk("thr2 reached", 12'h000, {11'h000, dav});
		$display("test data available done");

		bus_wr(12'h670);
		bus_wr(12'h045);
		chk("combined write", 12'h045, {2'h0, cr0});
		bus_rd(1'b1, v);
		chk("combined read cr0", 12'h045, v);
		bus_rd(1'b1, v);
		chk("combined read cr1", 12'h670, v);
		$display("test combined strobe done");
		tally_and_finish();
	end
endmodule

// ---- rtl/acr1_avail.sv ----
`timescale 1ns/1ps
module acr1_avail (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	// Control
	input wire logic clear,
	input wire logic pulse_mode,
	input wire logic active_high,
	input wire logic [4:0] thr,
	// FIFO and conversion clock
	input wire logic [4:0] fifo_level,
	input wire logic read_pulse,
	input wire logic conv_level,
	input wire logic conv_rise,
	// Output pin
	output logic data_available_out
);
	logic armed_r, armed_nxt, act_r, act_nxt, out_r, out_nxt;
	logic [4:0] reads_r, reads_nxt;
	logic trig;

	assign trig = armed_r && (fifo_level >= thr);
	assign data_available_out = out_r;

	always_comb begin
		armed_nxt = armed_r;
		act_nxt = act_r;
		reads_nxt = reads_r;
		// Rearm after a full threshold of reads, or at once on clear
		if (!armed_r && read_pulse) begin
			reads_nxt = reads_r + 5'h1;
			if (!pulse_mode) begin
				act_nxt = 1'b0;
			end
			if (reads_nxt == thr) begin
				armed_nxt = 1'b1;
				reads_nxt = 5'h00;
			end
		end
		if (pulse_mode && !conv_level) begin
			act_nxt = 1'b0;
		end
		if (trig && (!pulse_mode || conv_rise)) begin
			act_nxt = 1'b1;
			armed_nxt = 1'b0;
			reads_nxt = 5'h00;
		end
		if (clear) begin
			armed_nxt = 1'b1;
			act_nxt = 1'b0;
			reads_nxt = 5'h00;
		end
		out_nxt = (act_nxt == active_high);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			armed_r <= 1'b1;
			act_r <= 1'b0;
			reads_r <= 5'h00;
			out_r <= acr1_pkg::AV_RST;
		end else if (clk_en) begin
			armed_r <= armed_nxt;
			act_r <= act_nxt;
			reads_r <= reads_nxt;
			out_r <= out_nxt;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	property p_trig;
		!pulse_mode && trig && !clear && clk_en |=> act_r;
	endproperty
	a_trig: assert property (p_trig) else $error("no level on trigger");

	property p_read;
		!pulse_mode && act_r && read_pulse && !clear && clk_en |=> !act_r;
	endproperty
	a_read: assert property (p_read) else $error("level kept after read");

	property p_half;
		pulse_mode && act_r && !conv_level && clk_en |=> !act_r;
	endproperty
	a_half: assert property (p_half) else $error("pulse too long");

	property p_hold;
		!pulse_mode && act_r && !read_pulse && !clear && clk_en |=> act_r;
	endproperty
	a_hold: assert property (p_hold) else $error("level dropped");

	property p_pol;
		$rose(act_r) |-> data_available_out == $past(active_high);
	endproperty
	a_pol: assert property (p_pol) else $error("wrong polarity");

	c_pulse: cover property (pulse_mode && $rose(act_r) ##[1:40] !act_r);
endmodule

// ---- rtl/acr1_pkg.sv ----
package acr1_pkg;
	localparam int W = 12;
	localparam int CRW = 10;
	localparam logic [1:0] SEL_CR1 = 2'h1;
	localparam logic [1:0] SEL_CR0 = 2'h0;
	localparam int B_SRST = 0;
	localparam int B_OVF = 1;
	localparam int B_TRIG = 2;
	localparam int B_TRIG_HI = 3;
	localparam int B_TYPE = 4;
	localparam int B_POL = 5;
	localparam int B_RW = 6;
	localparam int B_FMT = 7;
	localparam int B_ZERO = 8;
	localparam int B_RBK = 9;
	localparam int B0_SCAN = 7;
	localparam logic [9:0] CR0_RST = 10'h020;
	localparam logic [9:0] CR1_RST = 10'h030;
	localparam logic [2:0] START_CNT = 3'h5;
	localparam logic [11:0] MID = 12'h800;
	localparam logic [11:0] OFS_RST = 12'h000;
	localparam logic [11:0] DOUT_RST = 12'h000;
	localparam logic AV_RST = 1'b0;
	localparam logic [16:0] SYNC_RST = 17'h0000d;
	localparam int S_CS0 = 0;
	localparam int S_CS1 = 1;
	localparam int S_RD = 2;
	localparam int S_WR = 3;
	localparam int S_CONV = 4;
	localparam int S_DAT = 5;
	localparam logic [4:0] TL1_0 = 5'h01;
	localparam logic [4:0] TL1_1 = 5'h04;
	localparam logic [4:0] TL1_2 = 5'h08;
	localparam logic [4:0] TL1_3 = 5'h0e;
	localparam logic [4:0] TL2_0 = 5'h02;
	localparam logic [4:0] TL2_1 = 5'h04;
	localparam logic [4:0] TL2_2 = 5'h08;
	localparam logic [4:0] TL2_3 = 5'h0c;

	typedef enum logic [0:0] {
		CAL_IDLE = 1'b0,
		CAL_WAIT = 1'b1
	} acr1_cal_t;

	function automatic logic [4:0] acr1_thr(input logic [1:0] code,
		input logic two);
		logic [4:0] t;
		t = TL1_0;
		unique case (code)
			2'h0: t = two ? TL2_0 : TL1_0;
			2'h1: t = two ? TL2_1 : TL1_1;
			2'h2: t = two ? TL2_2 : TL1_2;
			2'h3: t = two ? TL2_3 : TL1_3;
		endcase
		return t;
	endfunction
endpackage

// ---- rtl/acr1_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Soft reset bit restores both control registers
// - Soft reset also clears FIFO and offset
// - First sample enters FIFO on the fifth conversion clock rise after reset
// - Read bit 1 reports sticky FIFO overflow
// - Reading this register clears the overflow
// - Write bit 1 flushes the FIFO
// - Bits 2-3 set FIFO trigger threshold
// - Bit 4 selects level or pulse output
// - Bit 5 selects output active level
// - Bit 6 makes write pin combined strobe
// - Combined line high reads, low writes
// - Bit 6 clear: separate read and write strobes
// - Bit 7 selects twos complement or binary
// - Bit 8 converts zero input, stores offset
// - Stored offset subtracted from every result
// - Bit 9 enables control register readback
// - Readback returns register 0, then register 1
// - Threshold codes map per channel count
// - Level drops on first read, rearms later
// - Pulse lasts half a conversion clock
module acr1_top (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	// Processor bus pins
	input wire logic chip_select_low_n,
	input wire logic chip_select_high,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [acr1_pkg::W-1:0] bus_data_in,
	output logic [acr1_pkg::W-1:0] bus_data_out,
	output logic bus_data_oe,
	// Conversion core
	input wire logic conversion_clock_in,
	input wire logic [acr1_pkg::W-1:0] adc_sample_in,
	output logic force_zero_out,
	// FIFO
	input wire logic [4:0] fifo_level_in,
	input wire logic fifo_overflow_in,
	input wire logic [acr1_pkg::W-1:0] fifo_data_in,
	output logic fifo_wr_out,
	output logic [acr1_pkg::W-1:0] fifo_wdata_out,
	output logic fifo_rd_out,
	output logic fifo_flush_out,
	// Configuration and data available
	output logic [acr1_pkg::CRW-1:0] cr0_out,
	output logic data_available_out
);
	logic [16:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
	logic s_cs0n, s_cs1, s_rdn, s_wrn, s_conv;
	logic [acr1_pkg::W-1:0] s_data;
	logic cs_act, rd_int, wr_int, rd_rise, wr_fall, is_cr1;
	logic soft_rst, cal_go, rbk, conv_rise;
	logic [4:0] thr;
	logic [acr1_pkg::W-1:0] corr;

	logic rd_d_r, rd_d_nxt, wr_d_r, wr_d_nxt;
	logic [acr1_pkg::CRW-1:0] cr0_r, cr0_nxt, cr1_r, cr1_nxt;
	logic ovf_r, ovf_nxt, idx_r, idx_nxt;
	logic frd_r, frd_nxt, flush_r, flush_nxt;
	logic [acr1_pkg::W-1:0] dout_r, dout_nxt;

	acr1_pkg::acr1_cal_t cal_r, cal_nxt;
	logic [acr1_pkg::W-1:0] ofs_r, ofs_nxt, fwd_r, fwd_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic conv_d_r, conv_d_nxt, fwr_r, fwr_nxt;

	// Pin synchronisers, data included: bus is far slower than clk_sys
	always_comb begin
		sync1_nxt = {bus_data_in, conversion_clock_in, write_strobe_n,
			read_strobe_n, chip_select_high, chip_select_low_n};
		sync2_nxt = sync1_r;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sync1_r <= acr1_pkg::SYNC_RST;
			sync2_r <= acr1_pkg::SYNC_RST;
		end else if (clk_en) begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	assign s_cs0n = sync2_r[acr1_pkg::S_CS0];
	assign s_cs1 = sync2_r[acr1_pkg::S_CS1];
	assign s_rdn = sync2_r[acr1_pkg::S_RD];
	assign s_wrn = sync2_r[acr1_pkg::S_WR];
	assign s_conv = sync2_r[acr1_pkg::S_CONV];
	assign s_data = sync2_r[acr1_pkg::S_DAT +: acr1_pkg::W];

	// Strobe decode
	assign cs_act = !s_cs0n && s_cs1;
	assign rd_int = cs_act && (cr1_r[acr1_pkg::B_RW] ? s_wrn
		: (!s_rdn && s_wrn));
	assign wr_int = cs_act && (cr1_r[acr1_pkg::B_RW] ? !s_wrn
		: (!s_wrn && s_rdn));
	assign rd_rise = rd_int && !rd_d_r;
	assign wr_fall = wr_d_r && !wr_int;
	assign is_cr1 = s_data[11:10] == acr1_pkg::SEL_CR1;
	assign soft_rst = wr_fall && is_cr1 && s_data[acr1_pkg::B_SRST];
	assign cal_go = wr_fall && is_cr1 && s_data[acr1_pkg::B_ZERO];
	assign rbk = cr1_r[acr1_pkg::B_RBK];
	assign conv_rise = s_conv && !conv_d_r;
	assign thr = acr1_pkg::acr1_thr(cr1_r[acr1_pkg::B_TRIG_HI:acr1_pkg::B_TRIG],
		cr0_r[acr1_pkg::B0_SCAN]);

	// Register bank; written word is taken when the write strobe ends
	always_comb begin
		rd_d_nxt = rd_int;
		wr_d_nxt = wr_int;
		cr0_nxt = cr0_r;
		cr1_nxt = cr1_r;
		ovf_nxt = ovf_r;
		idx_nxt = idx_r;
		dout_nxt = dout_r;
		frd_nxt = 1'b0;
		flush_nxt = 1'b0;
		if (rd_rise) begin
			if (rbk) begin
				if (!idx_r) begin
					dout_nxt = {acr1_pkg::SEL_CR0, cr0_r};
				end else begin
					dout_nxt = {acr1_pkg::SEL_CR1, cr1_r[9:2], ovf_r, 1'b0};
					ovf_nxt = 1'b0;
				end
				idx_nxt = !idx_r;
			end else begin
				dout_nxt = fifo_data_in;
				frd_nxt = 1'b1;
			end
		end
		if (fifo_overflow_in) begin
			ovf_nxt = 1'b1;
		end
		if (wr_fall) begin
			if (is_cr1) begin
				cr1_nxt = {s_data[9:2], 2'h0};
				if (s_data[acr1_pkg::B_RBK]) begin
					idx_nxt = 1'b0;
				end
				if (s_data[acr1_pkg::B_OVF]) begin
					flush_nxt = 1'b1;
				end
			end else begin
				cr0_nxt = s_data[9:0];
			end
		end
		if (soft_rst) begin
			cr0_nxt = acr1_pkg::CR0_RST;
			cr1_nxt = acr1_pkg::CR1_RST;
			ovf_nxt = 1'b0;
			idx_nxt = 1'b0;
			flush_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rd_d_r <= 1'b0;
			wr_d_r <= 1'b0;
			cr0_r <= acr1_pkg::CR0_RST;
			cr1_r <= acr1_pkg::CR1_RST;
			ovf_r <= 1'b0;
			idx_r <= 1'b0;
			dout_r <= acr1_pkg::DOUT_RST;
			frd_r <= 1'b0;
			flush_r <= 1'b0;
		end else if (clk_en) begin
			rd_d_r <= rd_d_nxt;
			wr_d_r <= wr_d_nxt;
			cr0_r <= cr0_nxt;
			cr1_r <= cr1_nxt;
			ovf_r <= ovf_nxt;
			idx_r <= idx_nxt;
			dout_r <= dout_nxt;
			frd_r <= frd_nxt;
			flush_r <= flush_nxt;
		end
	end

	// Conversion path; offset assumes core latency is already aligned
	assign corr = adc_sample_in - ofs_r;

	always_comb begin
		cal_nxt = cal_r;
		ofs_nxt = ofs_r;
		cnt_nxt = cnt_r;
		conv_d_nxt = s_conv;
		fwr_nxt = 1'b0;
		fwd_nxt = fwd_r;
		if (conv_rise && cnt_r != 3'h0) begin
			cnt_nxt = cnt_r - 3'h1;
		end
		unique case (cal_r)
			acr1_pkg::CAL_WAIT: begin
				if (conv_rise) begin
					ofs_nxt = adc_sample_in - acr1_pkg::MID;
					cal_nxt = acr1_pkg::CAL_IDLE;
				end
			end
			acr1_pkg::CAL_IDLE: begin
				if (conv_rise && cnt_r <= 3'h1) begin
					fwr_nxt = 1'b1;
					fwd_nxt = cr1_r[acr1_pkg::B_FMT] ? corr
						: corr ^ acr1_pkg::MID;
				end
			end
		endcase
		if (cal_go) begin
			cal_nxt = acr1_pkg::CAL_WAIT;
		end
		if (soft_rst) begin
			cal_nxt = acr1_pkg::CAL_IDLE;
			ofs_nxt = acr1_pkg::OFS_RST;
			cnt_nxt = acr1_pkg::START_CNT;
			fwr_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cal_r <= acr1_pkg::CAL_IDLE;
			ofs_r <= acr1_pkg::OFS_RST;
			cnt_r <= acr1_pkg::START_CNT;
			conv_d_r <= 1'b0;
			fwr_r <= 1'b0;
			fwd_r <= acr1_pkg::DOUT_RST;
		end else if (clk_en) begin
			cal_r <= cal_nxt;
			ofs_r <= ofs_nxt;
			cnt_r <= cnt_nxt;
			conv_d_r <= conv_d_nxt;
			fwr_r <= fwr_nxt;
			fwd_r <= fwd_nxt;
		end
	end

	acr1_avail u_avail (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.clear(flush_r),
		.pulse_mode(cr1_r[acr1_pkg::B_TYPE]),
		.active_high(cr1_r[acr1_pkg::B_POL]),
		.thr(thr),
		.fifo_level(fifo_level_in),
		.read_pulse(frd_r),
		.conv_level(s_conv),
		.conv_rise(conv_rise),
		.data_available_out(data_available_out)
	);

	// Drive only once the word is loaded, never stale data
	assign bus_data_oe = rd_int && rd_d_r;
	assign bus_data_out = dout_r;
	assign force_zero_out = cal_r == acr1_pkg::CAL_WAIT;
	assign fifo_wr_out = fwr_r;
	assign fifo_wdata_out = fwd_r;
	assign fifo_rd_out = frd_r;
	assign fifo_flush_out = flush_r;
	assign cr0_out = cr0_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	property p_srst;
		soft_rst && clk_en |=> cr1_r == acr1_pkg::CR1_RST
			&& cr0_r == acr1_pkg::CR0_RST && fifo_flush_out;
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset missed");

	property p_ofsclr;
		soft_rst && clk_en |=> ofs_r == acr1_pkg::OFS_RST && !force_zero_out;
	endproperty
	a_ofsclr: assert property (p_ofsclr) else $error("offset kept");

	property p_start;
		soft_rst && clk_en |=> !fifo_wr_out [*4];
	endproperty
	a_start: assert property (p_start) else $error("early sample");

	property p_ovf;
		fifo_overflow_in && clk_en && !soft_rst |=> ovf_r;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow lost");

	property p_ovfclr;
		rd_rise && rbk && idx_r && !fifo_overflow_in && !soft_rst && clk_en
			|=> !ovf_r && bus_data_out[11:10] == acr1_pkg::SEL_CR1;
	endproperty
	a_ovfclr: assert property (p_ovfclr) else $error("flag not cleared");

	property p_flush;
		wr_fall && is_cr1 && s_data[acr1_pkg::B_OVF] && clk_en
			|=> fifo_flush_out ##1 !fifo_flush_out || $past(soft_rst);
	endproperty
	a_flush: assert property (p_flush) else $error("no flush");

	property p_comb;
		cr1_r[acr1_pkg::B_RW] && cs_act |-> rd_int == s_wrn && wr_int == !s_wrn;
	endproperty
	a_comb: assert property (p_comb) else $error("combined decode");

	property p_sep;
		!cr1_r[acr1_pkg::B_RW] && cs_act && !s_rdn && s_wrn |-> rd_int && !wr_int;
	endproperty
	a_sep: assert property (p_sep) else $error("read strobe ignored");

	property p_route;
		wr_fall && !is_cr1 && !soft_rst && clk_en |=> cr0_r == $past(s_data[9:0]);
	endproperty
	a_route: assert property (p_route) else $error("cr0 not written");

	property p_rbk0;
		rd_rise && rbk && !idx_r && clk_en
			|=> bus_data_out == {acr1_pkg::SEL_CR0, $past(cr0_r)};
	endproperty
	a_rbk0: assert property (p_rbk0) else $error("readback order");

	property p_cal;
		cal_r == acr1_pkg::CAL_WAIT && conv_rise && clk_en && !cal_go && !soft_rst
			|=> !force_zero_out && ofs_r == $past(adc_sample_in) - acr1_pkg::MID;
	endproperty
	a_cal: assert property (p_cal) else $error("offset not stored");

	c_srst: cover property (soft_rst ##[5:300] fifo_wr_out);
	c_rbk: cover property (rd_rise && rbk && idx_r && ovf_r);
	c_cal: cover property (cal_go ##[1:100] cal_r == acr1_pkg::CAL_IDLE);
endmodule
